// ===== hw/mrc_pkg.sv
// Package with register map, field positions, reset values and timing for the monitor block
package mrc_pkg;
  localparam logic [7:0] ADDR_LOW_BITS   = 8'h05;
  localparam logic [7:0] ADDR_IN5_HIGH   = 8'h0c;
  localparam logic [7:0] ADDR_IN6_HIGH   = 8'h0d;
  localparam logic [7:0] ADDR_IN7_HIGH   = 8'h0e;
  localparam logic [7:0] ADDR_IN8_HIGH   = 8'h0f;
  localparam logic [7:0] ADDR_PRIMARY    = 8'h18;
  localparam logic [7:0] ADDR_SECONDARY  = 8'h19;
  localparam logic [7:0] UNMAPPED_DATA   = 8'h00;

  localparam logic [7:0] PRIMARY_RESET   = 8'h00;
  localparam logic [7:0] SECONDARY_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET    = 8'h00;
  localparam logic [1:0] LOW_RESET       = 2'h0;

  // Primary control fields
  localparam int MONITOR_ENABLE_POS = 0;
  localparam int PAIR_SELECT_LSB    = 1;
  localparam int IRQ_DISABLE_POS    = 5;
  localparam int IRQ_POLARITY_POS   = 6;
  localparam int POWER_DOWN_POS     = 7;
  // Secondary control fields
  localparam int CHANNEL_SEL_LSB    = 0;
  localparam int SINGLE_MODE_POS    = 4;

  localparam logic [1:0] PAIR_INPUTS     = 2'h0;
  localparam logic [1:0] PAIR_DIODE      = 2'h2;

  // Conversion channel codes
  localparam logic [3:0] CH_FIRST        = 4'h0;
  localparam logic [3:0] CH_IN5          = 4'h6;
  localparam logic [3:0] CH_LAST         = 4'h9;
  localparam int         NUM_HIGH_INPUTS = 4;

  // Pacing between conversions
  localparam int CLK_PERIOD_NS   = 100;
  localparam int CONV_GAP_NS     = 100000;
  localparam int CONV_GAP_CYCLES = CONV_GAP_NS / CLK_PERIOD_NS;

  typedef enum logic [1:0] {ST_IDLE, ST_PACE, ST_CONVERT} mrc_state_t;
endpackage

// ===== hw/mrc_result_if.sv
// Interface carrying one conversion result between the sequencer and a result slice
`timescale 1ns/1ps
`default_nettype none
interface mrc_result_if;
  logic       capture;
  logic [9:0] data;
  logic [7:0] high;
  logic [1:0] low;
  modport slice (input capture, input data, output high, output low);
  modport owner (output capture, output data, input high, input low);
endinterface
`default_nettype wire

// ===== hw/mrc_pace_div.sv
// Divider giving a one-cycle pacing pulse while conversions run
`timescale 1ns/1ps
`default_nettype none
module mrc_pace_div #(
  parameter int CYCLES = 1000
) (
  input  wire logic i_clk,
  input  wire logic i_reset,
  input  wire logic i_run,
  output logic      o_tick
);
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic        tick_d;

  always_comb begin
    count_d = count_q;
    tick_d  = 1'b0;
    if (!i_run) begin
      count_d = 16'h0000;
    end else if (count_q == 16'(CYCLES - 1)) begin
      count_d = 16'h0000;
      tick_d  = 1'b1;
    end else begin
      count_d = 16'(count_q + 16'h0001);
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      count_q <= 16'h0000;
      o_tick  <= 1'b0;
    end else begin
      count_q <= count_d;
      o_tick  <= tick_d;
    end
  end
endmodule
`default_nettype wire

// ===== hw/mrc_result_slice.sv
// One 10-bit conversion result, split into upper eight and lower two bits
`timescale 1ns/1ps
`default_nettype none
module mrc_result_slice
  import mrc_pkg::*;
(
  input  wire logic   i_clk,
  input  wire logic   i_reset,
  mrc_result_if.slice bus
);
  logic [7:0] high_q;
  logic [7:0] high_d;
  logic [1:0] low_q;
  logic [1:0] low_d;

  // Only a finished conversion loads the slice; host writes never reach it
  always_comb begin
    high_d = high_q;
    low_d  = low_q;
    if (bus.capture) begin
      high_d = bus.data[9:2];
      low_d  = bus.data[1:0];
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      high_q <= RESULT_RESET;
      low_q  <= LOW_RESET;
    end else begin
      high_q <= high_d;
      low_q  <= low_d;
    end
  end

  assign bus.high = high_q;
  assign bus.low  = low_q;
endmodule
`default_nettype wire

// ===== hw/mrc_monitor_regs.sv
// Result and control registers of the monitor with its conversion sequencer
`timescale 1ns/1ps
`default_nettype none
// Contract
// - Offset 0c holds input five upper bits; low-bits register 05 bits 1:0 complete it.
// - Offset 0d holds input six upper bits; register 05 bits 3:2 complete it.
// - Offset 0e holds input seven upper bits; register 05 bits 5:4 complete it.
// - Offset 0f holds input eight upper bits; register 05 bits 7:6 complete it.
// - Conversions run only while monitor enable bit 0 is set, either mode.
// - Pair select code 00 routes inputs one and two, code 10 the diode.
// - Interrupt output driven only while its disable bit 5 is zero.
// - Interrupt polarity bit 6: zero active low, one active high.
// - Power-down bit 7 set stops analog and conversions; register access continues.
// - Writing power-down back to zero resumes normal operation.
// - Result registers and control one reset to zero.
// - Control two mode bit: zero round robin, one single channel.
module mrc_monitor_regs
  import mrc_pkg::*;
(
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  input  wire logic       i_wr_en,
  input  wire logic       i_rd_en,
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wr_data,
  input  wire logic       i_conv_done,
  input  wire logic [9:0] i_conv_data,
  input  wire logic       i_alarm,
  output logic      [7:0] o_rd_data,
  output logic            o_rd_valid,
  output logic            o_conv_start,
  output logic      [3:0] o_conv_channel,
  output logic            o_analog_power_en,
  output logic      [1:0] o_pair_select,
  output logic            o_irq,
  output logic            o_irq_oe
);
  logic [7:0] primary_q;
  logic [7:0] primary_d;
  logic [7:0] secondary_q;
  logic [7:0] secondary_d;

  logic       monitor_enable_bit;
  logic [1:0] input_pair_select;
  logic       irq_output_disable;
  logic       irq_polarity;
  logic       power_down_bit;
  logic       single_mode;
  logic [3:0] channel_sel;

  assign monitor_enable_bit = primary_q[MONITOR_ENABLE_POS];
  assign input_pair_select  = primary_q[PAIR_SELECT_LSB +: 2];
  assign irq_output_disable = primary_q[IRQ_DISABLE_POS];
  assign irq_polarity       = primary_q[IRQ_POLARITY_POS];
  assign power_down_bit     = primary_q[POWER_DOWN_POS];
  assign single_mode        = secondary_q[SINGLE_MODE_POS];
  assign channel_sel        = secondary_q[CHANNEL_SEL_LSB +: 4];

  // Control register writes; result offsets have no write path
  always_comb begin
    primary_d   = primary_q;
    secondary_d = secondary_q;
    if (i_wr_en) begin
      if (i_addr == ADDR_PRIMARY) begin
        primary_d = i_wr_data;
      end else if (i_addr == ADDR_SECONDARY) begin
        secondary_d = i_wr_data;
      end
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      primary_q   <= PRIMARY_RESET;
      secondary_q <= SECONDARY_RESET;
    end else begin
      primary_q   <= primary_d;
      secondary_q <= secondary_d;
    end
  end

  // Result slices for inputs five to eight
  mrc_result_if res_if [NUM_HIGH_INPUTS] ();
  mrc_state_t   state_q;
  mrc_state_t   state_d;
  logic   [3:0] chan_q;
  logic   [3:0] chan_d;
  logic   [3:0] rr_q;
  logic   [3:0] rr_d;
  logic         start_d;
  logic         run;
  logic         tick;
  logic         done_ok;
  logic   [7:0] high_word [NUM_HIGH_INPUTS];
  logic   [7:0] low_bits;

  assign done_ok = (state_q == ST_CONVERT) && i_conv_done;

  for (genvar g = 0; g < NUM_HIGH_INPUTS; g++) begin : g_result
    assign res_if[g].capture = done_ok && ((chan_q - CH_IN5) == 4'(g));
    assign res_if[g].data    = i_conv_data;
    assign high_word[g]      = res_if[g].high;
    assign low_bits[2*g +: 2] = res_if[g].low;
    mrc_result_slice u_slice (
      .i_clk   (i_clk),
      .i_reset (i_reset),
      .bus     (res_if[g])
    );
  end

  // Reserved single-channel codes start nothing
  assign run = monitor_enable_bit && !power_down_bit
               && (!single_mode || channel_sel <= CH_LAST);

  mrc_pace_div #(
    .CYCLES (CONV_GAP_CYCLES)
  ) u_pace (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_run   (run),
    .o_tick  (tick)
  );

  always_comb begin
    state_d = state_q;
    chan_d  = chan_q;
    rr_d    = rr_q;
    start_d = 1'b0;
    case (state_q)
      ST_IDLE: begin
        if (run) begin
          state_d = ST_PACE;
        end
      end
      ST_PACE: begin
        if (!run) begin
          state_d = ST_IDLE;
        end else if (tick) begin
          chan_d  = single_mode ? channel_sel : rr_q;
          start_d = 1'b1;
          state_d = ST_CONVERT;
        end
      end
      ST_CONVERT: begin
        if (!run) begin
          state_d = ST_IDLE;
        end else if (i_conv_done) begin
          state_d = ST_PACE;
          if (!single_mode) begin
            rr_d = (rr_q == CH_LAST) ? CH_FIRST : 4'(rr_q + 4'h1);
          end
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      state_q      <= ST_IDLE;
      chan_q       <= CH_FIRST;
      rr_q         <= CH_FIRST;
      o_conv_start <= 1'b0;
    end else begin
      state_q      <= state_d;
      chan_q       <= chan_d;
      rr_q         <= rr_d;
      o_conv_start <= start_d;
    end
  end

  assign o_conv_channel = chan_q;

  // Register reads, answered one cycle later
  logic [7:0] rd_data_d;

  always_comb begin
    rd_data_d = UNMAPPED_DATA;
    if (i_addr == ADDR_LOW_BITS) begin
      rd_data_d = low_bits;
    end else if (i_addr == ADDR_IN5_HIGH) begin
      rd_data_d = high_word[0];
    end else if (i_addr == ADDR_IN6_HIGH) begin
      rd_data_d = high_word[1];
    end else if (i_addr == ADDR_IN7_HIGH) begin
      rd_data_d = high_word[2];
    end else if (i_addr == ADDR_IN8_HIGH) begin
      rd_data_d = high_word[3];
    end else if (i_addr == ADDR_PRIMARY) begin
      rd_data_d = primary_q;
    end else if (i_addr == ADDR_SECONDARY) begin
      rd_data_d = secondary_q;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_rd_data  <= UNMAPPED_DATA;
      o_rd_valid <= 1'b0;
    end else begin
      o_rd_valid <= i_rd_en;
      if (i_rd_en) begin
        o_rd_data <= rd_data_d;
      end
    end
  end

  // Pin-facing outputs
  logic       power_en_d;
  logic [1:0] pair_d;
  logic       irq_d;
  logic       irq_oe_d;

  always_comb begin
    power_en_d = !power_down_bit;
    pair_d     = input_pair_select;
    irq_oe_d   = !irq_output_disable;
    irq_d      = i_alarm ? irq_polarity : !irq_polarity;
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_analog_power_en <= 1'b1;
      o_pair_select     <= PAIR_INPUTS;
      o_irq_oe          <= 1'b0;
      o_irq             <= 1'b1;
    end else begin
      o_analog_power_en <= power_en_d;
      o_pair_select     <= pair_d;
      o_irq_oe          <= irq_oe_d;
      o_irq             <= irq_d;
    end
  end

  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_capture_in5;
    (state_q == ST_CONVERT) && i_conv_done && (chan_q == CH_IN5);
  endsequence

  property p_in5_capture;
    s_capture_in5 |=> (high_word[0] == $past(i_conv_data[9:2]))
                      && (low_bits[1:0] == $past(i_conv_data[1:0]));
  endproperty
  a_in5_capture: assert property (p_in5_capture) else $error("input five not captured");

  property p_low_read;
    (i_rd_en && i_addr == ADDR_LOW_BITS) |=> o_rd_valid && (o_rd_data == $past(low_bits));
  endproperty
  a_low_read: assert property (p_low_read) else $error("low bits read wrong");

  property p_ro_write;
    (i_wr_en && i_addr == ADDR_IN7_HIGH && !done_ok) |=> $stable(high_word[2]);
  endproperty
  a_ro_write: assert property (p_ro_write) else $error("result changed by write");

  property p_start_enable;
    o_conv_start |-> $past(monitor_enable_bit) && !$past(power_down_bit);
  endproperty
  a_start_enable: assert property (p_start_enable) else $error("start while stopped");

  property p_power_down;
    power_down_bit |=> !o_analog_power_en && !o_conv_start;
  endproperty
  a_power_down: assert property (p_power_down) else $error("analog on in standby");

  sequence s_wake;
    $fell(power_down_bit);
  endsequence

  property p_wake;
    s_wake |=> o_analog_power_en;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake after power-down clear");

  property p_irq_disable;
    irq_output_disable |=> !o_irq_oe;
  endproperty
  a_irq_disable: assert property (p_irq_disable) else $error("irq driven while disabled");

  property p_irq_polarity;
    (!irq_output_disable && i_alarm) ##1 o_irq_oe |-> o_irq == $past(irq_polarity);
  endproperty
  a_irq_polarity: assert property (p_irq_polarity) else $error("irq level wrong");

  property p_pair;
    ##1 o_pair_select == $past(input_pair_select);
  endproperty
  a_pair: assert property (p_pair) else $error("pair select not routed");

  property p_reset_values;
    $fell(i_reset) |-> (primary_q == PRIMARY_RESET) && (high_word[3] == RESULT_RESET);
  endproperty
  a_reset_values: assert property (p_reset_values) else $error("reset value wrong");

  property p_single;
    (state_q == ST_PACE && tick && run && single_mode) |=> chan_q == $past(channel_sel);
  endproperty
  a_single: assert property (p_single) else $error("single channel not used");
endmodule
`default_nettype wire

// ===== test/mrc_conv_model.sv
// Converter partner model answering each conversion start with a done pulse
`timescale 1ns/1ps
`default_nettype none
module mrc_conv_model (
  input  wire logic       i_clk,
  input  wire logic       i_start,
  input  wire logic [3:0] i_channel,
  input  wire logic [5:0] i_base,
  output logic            o_done,
  output logic      [9:0] o_data
);
  logic       busy_q;
  logic [1:0] cnt_q;
  logic [3:0] ch_q;
  initial begin
    o_done = 1'b0;
    o_data = 10'h000;
    busy_q = 1'b0;
    cnt_q  = 2'h0;
    ch_q   = 4'h0;
  end
  always @(posedge i_clk) begin
    if (i_start) begin
      busy_q <= 1'b1;
      cnt_q  <= 2'h3;
      ch_q   <= i_channel;
    end else if (busy_q) begin
      cnt_q <= cnt_q - 2'h1;
      if (cnt_q == 2'h1) begin
        busy_q <= 1'b0;
      end
    end
    // Data only meaningful alongside done
    if (!i_start && busy_q && cnt_q == 2'h1) begin
      o_done <= 1'b1;
      o_data <= {i_base, ch_q};
    end else begin
      o_done <= 1'b0;
      o_data <= ~o_data;
    end
  end
endmodule
`default_nettype wire

// ===== test/mrc_monitor_regs_bench.sv
// Self-checking bench for the monitor result and control registers
`timescale 1ns/1ps
`default_nettype none
module mrc_monitor_regs_bench;
  import mrc_pkg::*;
  logic       clk, rst, wr_en, rd_en, done, alarm, start, irq, irq_oe, pwr, rd_valid;
  logic [7:0] addr, wdata, rd_data, v, lowexp;
  logic [9:0] cdata;
  logic [3:0] chan, c1;
  logic [1:0] pair;
  logic [5:0] base;
  int         n_fail, samples_checked, n;
  int unsigned rng = 93;

  mrc_monitor_regs DUT (.i_clk(clk), .i_reset(rst), .i_wr_en(wr_en), .i_rd_en(rd_en),
    .i_addr(addr), .i_wr_data(wdata), .i_conv_done(done), .i_conv_data(cdata),
    .i_alarm(alarm), .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_conv_start(start),
    .o_conv_channel(chan), .o_analog_power_en(pwr), .o_pair_select(pair), .o_irq(irq),
    .o_irq_oe(irq_oe));
  mrc_conv_model PARTNER (.i_clk(clk), .i_start(start), .i_channel(chan), .i_base(base),
    .o_done(done), .o_data(cdata));

  function automatic logic [7:0] rnd();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng[7:0];
  endfunction

  function automatic logic [3:0] next_ch(input logic [3:0] c);
    return (c == CH_LAST) ? CH_FIRST : 4'(c + 4'h1);
  endfunction

  task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] s);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic chk1(input string nm, input logic e, input logic s);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %b seen %b", nm, e, s);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    addr  = a;
    wdata = d;
    wr_en = 1'b1;
    @(posedge clk);
    #10 wr_en = 1'b0;
    @(posedge clk);
    #10;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e, input string nm);
    addr  = a;
    rd_en = 1'b1;
    @(posedge clk);
    #10 rd_en = 1'b0;
    chk1("rd_valid", 1'b1, rd_valid);
    chk8(nm, e, rd_data);
    @(posedge clk);
    #10;
    chk1("rd_valid_end", 1'b0, rd_valid);
  endtask

  // Counts starts over up to n cycles, optionally stopping at the first
  task automatic watch(input int cyc, input bit stop, output int cnt);
    cnt = 0;
    for (int i = 0; i < cyc; i++) begin
      @(posedge clk);
      #10;
      if (start === 1'b1) begin
        cnt++;
        if (stop) break;
      end
    end
  endtask

  task automatic settle(input int k);
    repeat (k) @(posedge clk);
    #10;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial begin
    #4000000;
    n_fail++;
    finish_test();
  end

  initial begin
    rst = 1'b1;
    {wr_en, rd_en, alarm} = 3'h0;
    addr   = 8'h00;
    wdata  = 8'h00;
    base   = 6'h00;
    lowexp = 8'h00;
    repeat (4) @(posedge clk);
    #10 rst = 1'b0;
    settle(1);
    for (int a = 12; a < 16; a++) rd(8'(a), RESULT_RESET, "result_high");
    rd(ADDR_PRIMARY, PRIMARY_RESET, "primary");
    rd(8'h20, UNMAPPED_DATA, "unmapped");
    chk1("irq_oe", 1'b1, irq_oe);
    chk1("power", 1'b1, pwr);
    $display("test reset done");

    for (int i = 0; i < 8; i++) begin
      v = rnd();
      v[0] = 1'b0;
      v[3] = 1'b1;
      v[4] = 1'b0;
      v[2:1] = i[0] ? PAIR_DIODE : PAIR_INPUTS;
      alarm = v[0] ^ rng[9];
      wr(ADDR_PRIMARY, v);
      settle(2);
      chk8("pair", {6'h00, v[2:1]}, {6'h00, pair});
      chk1("irq_oe", ~v[5], irq_oe);
      chk1("irq", alarm ? v[6] : ~v[6], irq);
      chk1("power", ~v[7], pwr);
      rd(ADDR_PRIMARY, v, "primary");
    end
    $display("test control done");

    wr(ADDR_PRIMARY, 8'h09);
    for (int ch = 6; ch < 10; ch++) begin
      v = rnd();
      base = v[5:0];
      wr(ADDR_SECONDARY, 8'h10 | 8'(ch));
      watch(2500, 1'b1, n);
      chk8("starts", 8'h01, 8'(n));
      chk8("channel", 8'(ch), {4'h0, chan});
      settle(6);
      lowexp[2*(ch-6) +: 2] = 2'(ch);
      rd(ADDR_IN5_HIGH + 8'(ch - 6), {base, 2'(ch >> 2)}, "high");
      wr(ADDR_IN5_HIGH + 8'(ch - 6), 8'hff);
      rd(ADDR_IN5_HIGH + 8'(ch - 6), {base, 2'(ch >> 2)}, "ro_high");
      rd(ADDR_LOW_BITS, lowexp, "low_bits");
    end
    $display("test single channel done");

    wr(ADDR_PRIMARY, 8'h08);
    watch(2500, 1'b0, n);
    chk8("stopped", 8'h00, 8'(n));
    wr(ADDR_PRIMARY, 8'h89);
    watch(2500, 1'b0, n);
    chk8("standby", 8'h00, 8'(n));
    chk1("power", 1'b0, pwr);
    rd(ADDR_PRIMARY, 8'h89, "standby_rd");
    wr(ADDR_SECONDARY, 8'h00);
    wr(ADDR_PRIMARY, 8'h09);
    watch(2500, 1'b1, n);
    chk8("resume", 8'h01, 8'(n));
    c1 = CH_FIRST;
    chk8("robin", {4'h0, c1}, {4'h0, chan});
    for (int k = 0; k < 10; k++) begin
      c1 = next_ch(c1);
      watch(2500, 1'b1, n);
      chk8("robin", {4'h0, c1}, {4'h0, chan});
    end
    $display("test power and mode done");

    rst = 1'b1;
    settle(4);
    rst = 1'b0;
    settle(1);
    for (int a = 12; a < 16; a++) rd(8'(a), RESULT_RESET, "reset_high");
    rd(ADDR_LOW_BITS, 8'h00, "reset_low");
    rd(ADDR_PRIMARY, PRIMARY_RESET, "reset_primary");
    chk1("power", 1'b1, pwr);
    $display("test mid-run reset done");
    finish_test();
  end
endmodule
`default_nettype wire
